// *** src/power_ctl_pkg.sv ***
/*
  Shared constants and types of the power control pin logic:
  timing counts, indices of the synchronised input vector and state types.
  Assumes a 100 MHz core clock.
*/
package power_ctl_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS       = 10;
  localparam int unsigned SLEEP_QUAL_TIME_NS  = 1000;
  localparam int unsigned SLEEP_QUAL_CYCLES   =
    (SLEEP_QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COLD_START_TIME_NS  = 2000;
  localparam int unsigned COLD_START_CYCLES   =
    (COLD_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_STEP_TIME_NS = 100;
  localparam int unsigned RESTART_STEP_CYCLES =
    (RESTART_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned RESTART_HOLD_S  = 12;
  localparam longint unsigned LONG_PRESS_CYCLES =
    (RESTART_HOLD_S * 64'd1_000_000_000) / CLK_PERIOD_NS;

  // Reset values of software bits
  localparam logic FULL_RESTART_ENABLE_RESET = 1'b0;
  localparam logic USB_SWITCH_RESET          = 1'b0;

  // Indices into the synchronised input vector
  localparam int unsigned IN_WDOG      = 0;
  localparam int unsigned IN_SLEEP1    = 1;
  localparam int unsigned IN_SLEEP2    = 2;
  localparam int unsigned IN_KEY1      = 3;
  localparam int unsigned IN_KEY2      = 4;
  localparam int unsigned IN_KEY3      = 5;
  localparam int unsigned IN_CS        = 6;
  localparam int unsigned IN_MOSI      = 7;
  localparam int unsigned IN_CLK32     = 8;
  localparam int unsigned IN_SCL       = 9;
  localparam int unsigned IN_SDA       = 10;
  localparam int unsigned IN_UID_FLOAT = 11;
  localparam int unsigned IN_UID_GND   = 12;
  localparam int unsigned IN_MODE_DIG  = 13;
  localparam int unsigned IN_MODE_ANA  = 14;
  localparam int unsigned IN_PROF1     = 15;
  localparam int unsigned IN_PROF2     = 16;
  localparam int unsigned ASYNC_W      = 17;

  typedef enum logic [2:0] {
    PM_OFF, PM_COLD_START, PM_ON, PM_STANDBY,
    PM_RST_POWER_DOWN, PM_RST_CHARGER_OFF, PM_RST_REG_DEFAULT
  } pm_state_t;

  typedef enum logic [1:0] {OPMODE_NORMAL, OPMODE_USB_LP_BOOT, OPMODE_TEST} op_mode_t;

  typedef enum logic [1:0] {UID_FLOATING, UID_GROUNDED, UID_FACTORY} uid_sense_t;
endpackage : power_ctl_pkg

// *** src/power_control_pin_logic.sv ***
/*
  Control-pin logic of a power management device: keep-alive watch,
  standby qualification, power keys with long-press full restart,
  cold-start straps, interface pin muxing, interrupt and slow clocks.
  Assumes all pin levels arrive as plain inputs on core_clk and that
  software bits are written through one-cycle write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module power_control_pin_logic #(
  parameter int unsigned LONG_PRESS_CYCLES  = 32'(power_ctl_pkg::LONG_PRESS_CYCLES),
  parameter int unsigned SLEEP_QUAL_CYCLES  = power_ctl_pkg::SLEEP_QUAL_CYCLES,
  parameter bit          RESTART_ACTIVE_LOW = 1'b1,
  parameter int unsigned IRQ_W              = 8
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     watchdog_keepalive_in,
  input  wire logic                     wdog_fail_to_cold_start,
  input  wire logic                     primary_sleep_request,
  input  wire logic                     secondary_sleep_request,
  input  wire logic                     primary_sleep_active_high,
  input  wire logic                     secondary_sleep_active_high,
  input  wire logic                     power_key_one,
  input  wire logic                     power_key_two,
  input  wire logic                     power_key_three,
  input  wire logic                     restart_enable_wr,
  input  wire logic                     restart_enable_wdata,
  input  wire logic                     usb_switch_wr,
  input  wire logic                     usb_switch_wdata,
  input  wire logic                     startup_profile_strap_one,
  input  wire logic                     startup_profile_strap_two,
  input  wire logic                     mode_strap_above_dig,
  input  wire logic                     mode_strap_above_ana,
  input  wire logic                     chip_select_pin,
  input  wire logic                     data_in_pin,
  input  wire logic                     serial_clk_pin,
  input  wire logic                     data_out_pin_in,
  input  wire logic                     core_miso,
  input  wire logic                     core_miso_en,
  input  wire logic                     core_sda_pull_low,
  input  wire logic [IRQ_W-1:0]         irq_pending,
  input  wire logic [IRQ_W-1:0]         irq_mask,
  input  wire logic                     slow_clk_in,
  input  wire logic                     host_clk_lpoff_stop,
  input  wire logic                     usb_id_float_cmp,
  input  wire logic                     usb_id_gnd_cmp,
  output logic                          full_restart_enable_bit,
  output logic                          usb_reg_input_switch,
  output logic                          usb_bus_to_supply_on,
  output power_ctl_pkg::pm_state_t      power_state,
  output logic                          standby_event,
  output logic                          charger_enable,
  output logic                          regs_to_default,
  output logic                          periph_reset_n,
  output logic                          host_reset_n,
  output logic [1:0]                    startup_profile,
  output power_ctl_pkg::op_mode_t       op_mode,
  output logic                          iface_is_i2c,
  output logic                          i2c_addr_a0,
  output logic                          core_serial_clk,
  output logic                          core_sda_in,
  output logic                          data_out_pin_out,
  output logic                          data_out_pin_oe_n,
  output logic                          int_out,
  output logic                          periph_slow_clock_out,
  output logic                          host_slow_clock_out,
  output power_ctl_pkg::uid_sense_t     usb_id_sense
);
  import power_ctl_pkg::*;

  if (LONG_PRESS_CYCLES < 2 || SLEEP_QUAL_CYCLES < 1 || SLEEP_QUAL_CYCLES > 65535
      || IRQ_W < 1) begin : g_bad_param
    $error("power_control_pin_logic: parameter out of range");
  end

  typedef struct packed {
    logic [ASYNC_W-1:0] sync1;
    logic [ASYNC_W-1:0] sync2;
    logic [1:0]         sleep_q;
    logic [1:0][15:0]   qual_cnt;
    logic [2:0]         keys_prev;
    logic [31:0]        press_cnt;
    logic [15:0]        seq_cnt;
    pm_state_t          state;
    logic               restart_en;
    logic               usb_sw;
    logic               host_clk_en;
    logic               standby_ev;
    logic               chg_en;
    logic               reg_default;
    logic               rst_n;
    logic [1:0]         profile;
    op_mode_t           mode;
    logic               i2c;
    logic               a0;
    logic               ser_clk;
    logic               sda_in;
    logic               dout;
    logic               dout_oe_n;
    logic               irq;
    logic               pclk;
    logic               hclk;
    uid_sense_t         usb_id_pin;
  } core_state_t;

  core_state_t cur;
  core_state_t next_cur;
  logic [ASYNC_W-1:0] raw_in;

  // Level of a sleep request as an assertion under its polarity
  function automatic logic sleep_asserted(input logic level, input logic active_high);
    return active_high ? level : ~level;
  endfunction : sleep_asserted

  // Decode of the mode strap comparators
  function automatic op_mode_t mode_decode(input logic above_dig, input logic above_ana);
    if (above_ana) begin
      return OPMODE_TEST;
    end
    return above_dig ? OPMODE_USB_LP_BOOT : OPMODE_NORMAL;
  endfunction : mode_decode

  // Gather every asynchronous pin into one vector, highest index first
  assign raw_in = {startup_profile_strap_two, startup_profile_strap_one, mode_strap_above_ana,
                   mode_strap_above_dig, usb_id_gnd_cmp, usb_id_float_cmp, data_out_pin_in,
                   serial_clk_pin, slow_clk_in, data_in_pin, chip_select_pin, power_key_three,
                   power_key_two, power_key_one, secondary_sleep_request, primary_sleep_request,
                   watchdog_keepalive_in};

  // Next-state logic of the whole block
  always_comb begin
    logic [2:0] keys_now;
    logic [1:0] sleep_s;
    logic       turn_on;
    logic       key3_release;
    logic       long_press;
    logic       restart_go;
    keys_now     = '0;
    sleep_s      = '0;
    turn_on      = 1'b0;
    key3_release = 1'b0;
    long_press   = 1'b0;
    restart_go   = 1'b0;
    next_cur     = cur;
    next_cur.sync1 = raw_in;
    next_cur.sync2 = cur.sync1;
    // Sleep request qualification: level must hold for the full count
    sleep_s = {cur.sync2[IN_SLEEP2], cur.sync2[IN_SLEEP1]};
    for (int i = 0; i < 2; i++) begin
      if (sleep_s[i] == cur.sleep_q[i]) begin
        next_cur.qual_cnt[i] = '0;
      end else if (cur.qual_cnt[i] >= 16'(SLEEP_QUAL_CYCLES - 1)) begin
        next_cur.sleep_q[i]  = sleep_s[i];
        next_cur.qual_cnt[i] = '0;
      end else begin
        next_cur.qual_cnt[i] = cur.qual_cnt[i] + 16'h0001;
      end
    end
    next_cur.standby_ev =
      sleep_asserted(cur.sleep_q[0], primary_sleep_active_high) &
      sleep_asserted(cur.sleep_q[1], secondary_sleep_active_high);
    // Power keys are active low; a falling edge is a turn-on event
    keys_now           = {cur.sync2[IN_KEY3], cur.sync2[IN_KEY2], cur.sync2[IN_KEY1]};
    next_cur.keys_prev = keys_now;
    turn_on            = |(cur.keys_prev & ~keys_now);
    key3_release       = ~cur.keys_prev[2] & keys_now[2];
    long_press         = cur.press_cnt > LONG_PRESS_CYCLES;
    if (!keys_now[2]) begin
      if (!long_press) begin
        next_cur.press_cnt = cur.press_cnt + 32'h0000_0001;
      end
    end else begin
      next_cur.press_cnt = '0;
    end

    // Software bits take their new value on the cycle after the strobe
    if (restart_enable_wr) begin
      next_cur.restart_en = restart_enable_wdata;
    end
    if (usb_switch_wr) begin
      next_cur.usb_sw = usb_switch_wdata;
    end
    restart_go = key3_release & long_press &
                 (RESTART_ACTIVE_LOW ? ~cur.restart_en : cur.restart_en);

    // Power mode sequencer
    next_cur.reg_default = 1'b0;
    next_cur.seq_cnt     = cur.seq_cnt + 16'h0001;
    unique case (cur.state)
      PM_OFF: begin
        next_cur.seq_cnt = '0;
        if (turn_on) begin
          next_cur.state = PM_COLD_START;
        end
      end
      PM_COLD_START: begin
        if (cur.seq_cnt == 16'h0000) begin
          next_cur.i2c         = cur.sync2[IN_CS];
          next_cur.a0          = cur.sync2[IN_MOSI];
          next_cur.profile     = {cur.sync2[IN_PROF2], cur.sync2[IN_PROF1]};
          next_cur.mode        = mode_decode(cur.sync2[IN_MODE_DIG],
                                             cur.sync2[IN_MODE_ANA]);
          next_cur.host_clk_en = 1'b1;
        end
        if (cur.seq_cnt >= 16'(COLD_START_CYCLES - 1)) begin
          next_cur.state   = PM_ON;
          next_cur.seq_cnt = '0;
        end
      end
      PM_ON, PM_STANDBY: begin
        next_cur.seq_cnt = '0;
        if (restart_go) begin
          next_cur.state = PM_RST_POWER_DOWN;
        end else if (!cur.sync2[IN_WDOG]) begin
          next_cur.state = wdog_fail_to_cold_start ? PM_COLD_START : PM_OFF;
        end else begin
          next_cur.state = cur.standby_ev ? PM_STANDBY : PM_ON;
        end
      end
      PM_RST_POWER_DOWN: begin
        if (cur.seq_cnt >= 16'(RESTART_STEP_CYCLES - 1)) begin
          next_cur.state   = PM_RST_CHARGER_OFF;
          next_cur.seq_cnt = '0;
        end
      end
      PM_RST_CHARGER_OFF: begin
        next_cur.chg_en = 1'b0;
        if (cur.seq_cnt >= 16'(RESTART_STEP_CYCLES - 1)) begin
          next_cur.state   = PM_RST_REG_DEFAULT;
          next_cur.seq_cnt = '0;
        end
      end
      PM_RST_REG_DEFAULT: begin
        next_cur.reg_default = 1'b1;
        next_cur.restart_en  = FULL_RESTART_ENABLE_RESET;
        next_cur.usb_sw      = USB_SWITCH_RESET;
        next_cur.chg_en      = 1'b1;
        next_cur.state       = PM_COLD_START;
        next_cur.seq_cnt     = '0;
      end
    endcase
    next_cur.rst_n = (next_cur.state == PM_ON) || (next_cur.state == PM_STANDBY);
    // Interface pin muxing between SPI and I2C
    next_cur.ser_clk = cur.sync2[IN_SCL];
    next_cur.sda_in  = cur.sync2[IN_SDA];
    if (cur.i2c) begin
      next_cur.dout      = 1'b0;
      next_cur.dout_oe_n = ~core_sda_pull_low;
    end else begin
      next_cur.dout      = core_miso;
      next_cur.dout_oe_n = ~core_miso_en;
    end
    next_cur.irq = |(irq_pending & ~irq_mask);
    // Slow clocks: peripheral one only in start-up and On
    next_cur.pclk = cur.sync2[IN_CLK32] &
                    ((cur.state == PM_COLD_START) || (cur.state == PM_ON));
    next_cur.hclk = cur.sync2[IN_CLK32] & cur.host_clk_en &
                    ~((cur.state == PM_OFF) && host_clk_lpoff_stop);
    // USB id sense
    if (cur.sync2[IN_UID_GND]) begin
      next_cur.usb_id_pin = UID_GROUNDED;
    end else if (cur.sync2[IN_UID_FLOAT]) begin
      next_cur.usb_id_pin = UID_FLOATING;
    end else begin
      next_cur.usb_id_pin = UID_FACTORY;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur            <= '0;
      cur.keys_prev  <= 3'h7;
      cur.sync1[IN_KEY3:IN_KEY1] <= 3'h7;                          // Idle keys, no false press
      cur.sync2[IN_KEY3:IN_KEY1] <= 3'h7;
      cur.restart_en <= FULL_RESTART_ENABLE_RESET;
      cur.usb_sw     <= USB_SWITCH_RESET;
      cur.state      <= PM_OFF;
      cur.chg_en     <= 1'b1;
      cur.mode       <= OPMODE_NORMAL;
      cur.dout_oe_n  <= 1'b1;
      cur.usb_id_pin        <= UID_FLOATING;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign full_restart_enable_bit = cur.restart_en;
  assign usb_reg_input_switch    = cur.usb_sw;
  assign usb_bus_to_supply_on    = cur.usb_sw;
  assign power_state             = cur.state;
  assign standby_event           = cur.standby_ev;
  assign charger_enable          = cur.chg_en;
  assign regs_to_default         = cur.reg_default;
  assign periph_reset_n          = cur.rst_n;
  assign host_reset_n            = cur.rst_n;
  assign startup_profile         = cur.profile;
  assign op_mode                 = cur.mode;
  assign iface_is_i2c            = cur.i2c;
  assign i2c_addr_a0             = cur.a0;
  assign core_serial_clk         = cur.ser_clk;
  assign core_sda_in             = cur.sda_in;
  assign data_out_pin_out        = cur.dout;
  assign data_out_pin_oe_n       = cur.dout_oe_n;
  assign int_out                 = cur.irq;
  assign periph_slow_clock_out   = cur.pclk;
  assign host_slow_clock_out     = cur.hclk;
  assign usb_id_sense            = cur.usb_id_pin;
endmodule : power_control_pin_logic
`default_nettype wire

// *** verif/pin_host_model.sv ***
/* Far-side model: power keys with an open-drain pull-down, chip select strap, SDA wire.
   Assumes the bench commands presses and straps on core_clk edges. */
`timescale 1ns/1ps
`default_nettype none
module pin_host_model (
  input  wire logic [2:0] press,
  input  wire logic       cs_high,
  input  wire logic       sda_oe_n,
  input  wire logic       sda_out,
  output logic      [2:0] key_n,
  output logic            cs_pin,
  output logic            sda_wire
);
  // Pull-down acts in parallel with each key, keys are active low
  assign key_n = ~press;
  // Chip select stays low unless strapped high for the two-wire bus
  assign cs_pin = cs_high;
  // SDA falls back to its pull-up once the device lets go
  assign sda_wire = sda_oe_n ? 1'b1 : sda_out;
endmodule : pin_host_model
`default_nettype wire

// *** verif/pcpl_props.sv ***
/* Checker of the power control pin logic, bound to its ports.
   Assumes rst is synchronous, active high, on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module pcpl_props #(
  parameter int unsigned IRQ_W = 8
) (
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire logic                     primary_sleep_request,
  input wire logic                     secondary_sleep_request,
  input wire logic                     primary_sleep_active_high,
  input wire logic                     secondary_sleep_active_high,
  input wire logic                     power_key_one,
  input wire logic                     restart_enable_wr,
  input wire logic                     restart_enable_wdata,
  input wire logic                     usb_switch_wr,
  input wire logic                     usb_switch_wdata,
  input wire logic                     serial_clk_pin,
  input wire logic [IRQ_W-1:0]         irq_pending,
  input wire logic [IRQ_W-1:0]         irq_mask,
  input wire logic                     full_restart_enable_bit,
  input wire logic                     usb_reg_input_switch,
  input wire power_ctl_pkg::pm_state_t power_state,
  input wire logic                     standby_event,
  input wire logic                     charger_enable,
  input wire logic                     regs_to_default,
  input wire logic                     core_serial_clk,
  input wire logic                     int_out
);
  import power_ctl_pkg::*;
  logic irq_any;
  logic pri_act;
  logic sec_act;
  // Unmasked events and sleep levels seen through their polarity
  assign irq_any = |(irq_pending & ~irq_mask);
  assign pri_act = primary_sleep_request == primary_sleep_active_high;
  assign sec_act = secondary_sleep_request == secondary_sleep_active_high;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Steps that follow the start of power-down
  sequence s_restart_steps;
    ##10 power_state == PM_RST_CHARGER_OFF ##1 !charger_enable
    ##9 power_state == PM_RST_REG_DEFAULT ##1 power_state == PM_COLD_START && regs_to_default;
  endsequence
  a_int_unmasked: assert property (1'b1 |=> int_out == $past(irq_any))
    else $error("int_out disagrees with unmasked events");
  a_usb_write: assert property (usb_switch_wr |=> usb_reg_input_switch == $past(usb_switch_wdata))
    else $error("usb switch bit missed a write");
  a_restart_write: assert property (restart_enable_wr |=> full_restart_enable_bit == $past(restart_enable_wdata))
    else $error("restart enable bit missed a write");
  a_key_turn_on: assert property (power_state == PM_OFF && $fell(power_key_one) |-> ##[1:4] power_state == PM_COLD_START)
    else $error("key press did not start");
  a_standby_both: assert property ($rose(standby_event) |-> pri_act && sec_act)
    else $error("standby without both requests");
  a_sleep_off: assert property (power_state == PM_OFF |=> power_state inside {PM_OFF, PM_COLD_START})
    else $error("left off other than by cold start");
  a_restart_order: assert property ($rose(power_state == PM_RST_POWER_DOWN) |-> s_restart_steps)
    else $error("restart steps out of order");
  a_sclk_sync: assert property (core_serial_clk == $past(serial_clk_pin, 3))
    else $error("serial clock latency wrong");
endmodule : pcpl_props
bind power_control_pin_logic pcpl_props #(.IRQ_W(IRQ_W)) u_pcpl_props (.*);
`default_nettype wire

// *** verif/power_control_pin_logic_test.sv ***
/* Bench of the power control pin logic: irq, bits, turn-on, standby, restart, keep-alive.
   Assumes the far-side model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module power_control_pin_logic_test;
  import power_ctl_pkg::*;
  logic core_clk = 0, rst = 1, watchdog_keepalive_in = 1, wdog_fail_to_cold_start = 0;
  logic primary_sleep_request = 1, secondary_sleep_request = 0, core_sda_pull_low = 0;
  logic primary_sleep_active_high = 1, secondary_sleep_active_high = 0, data_in_pin = 0;
  logic restart_enable_wr = 0, restart_enable_wdata = 0, usb_switch_wr = 0, usb_switch_wdata = 0;
  logic startup_profile_strap_one = 0, startup_profile_strap_two = 0, serial_clk_pin = 0;
  logic mode_strap_above_dig = 0, mode_strap_above_ana = 0, core_miso = 0, core_miso_en = 0;
  logic slow_clk_in = 1, host_clk_lpoff_stop = 0, usb_id_float_cmp = 0, usb_id_gnd_cmp = 0;
  logic cs_high = 0;
  logic [2:0] press = '0;
  logic [7:0] irq_pending = '0, irq_mask = '0;
  wire logic power_key_one, power_key_two, power_key_three, chip_select_pin, data_out_pin_in;
  logic full_restart_enable_bit, usb_reg_input_switch, usb_bus_to_supply_on, standby_event;
  logic charger_enable, regs_to_default, periph_reset_n, host_reset_n, iface_is_i2c;
  logic i2c_addr_a0, core_serial_clk, core_sda_in, data_out_pin_out, data_out_pin_oe_n, int_out;
  logic periph_slow_clock_out, host_slow_clock_out;
  logic [1:0] startup_profile;
  pm_state_t power_state;
  op_mode_t op_mode;
  uid_sense_t usb_id_sense;
  int fails = 0, num_checks = 0;
  // Device with short counts
  power_control_pin_logic #(.LONG_PRESS_CYCLES(50), .SLEEP_QUAL_CYCLES(4)) u_power_control_pin_logic (.*);
  // Far side of the pins
  pin_host_model u_pin_host_model (
    .press(press), .cs_high(cs_high), .sda_oe_n(data_out_pin_oe_n), .sda_out(data_out_pin_out),
    .key_n({power_key_three, power_key_two, power_key_one}),
    .cs_pin(chip_select_pin), .sda_wire(data_out_pin_in)
  );
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  task automatic stop_test;
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic wait_st(input pm_state_t s, input int lim);
    #1;
    for (int i = 0; i < lim && power_state !== s; i++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : wait_st
  task automatic wr(input bit usb, input logic v);
    tick(1);
    if (usb) begin
      usb_switch_wr <= 1;
      usb_switch_wdata <= v;
    end else begin
      restart_enable_wr <= 1;
      restart_enable_wdata <= v;
    end
    tick(1);
    usb_switch_wr <= 0;
    restart_enable_wr <= 0;
    tick(1);
    #1;
  endtask : wr
  task automatic straps(input logic i2c, input logic [1:0] prof, input op_mode_t md);
    cs_high <= i2c;
    data_in_pin <= i2c;
    {startup_profile_strap_two, startup_profile_strap_one} <= prof;
    mode_strap_above_dig <= md != OPMODE_NORMAL;
    mode_strap_above_ana <= md == OPMODE_TEST;
  endtask : straps
  task automatic chk_straps(input logic i2c, input logic [1:0] prof, input op_mode_t md);
    chk(power_state, PM_ON);
    chk(host_reset_n, 1);
    chk(iface_is_i2c, i2c);
    chk(i2c_addr_a0, i2c);
    chk(startup_profile, prof);
    chk(op_mode, md);
    chk(periph_reset_n, 1);
    chk(periph_slow_clock_out, 1);
    chk(host_slow_clock_out, 1);
  endtask : chk_straps
  task automatic t_on(input int k, input logic i2c, input logic [1:0] prof, input op_mode_t md);
    tick(1);
    press[k] <= 1;
    straps(i2c, prof, md);
    wait_st(PM_COLD_START, 10);
    chk(power_state, PM_COLD_START);
    tick(1);
    press[k] <= 0;
    wait_st(PM_ON, 300);
    chk_straps(i2c, prof, md);
  endtask : t_on
  task automatic sleep(input logic p, input logic s, input int n);
    tick(1);
    primary_sleep_request <= p;
    secondary_sleep_request <= s;
    tick(n);
    #1;
  endtask : sleep
  task automatic key3(input int n);
    tick(1);
    press[2] <= 1;
    tick(n);
    press[2] <= 0;
    tick(10);
    #1;
  endtask : key3
  task automatic t_basics;
    logic [7:0] p [3] = '{8'h00, 8'h81, 8'h10};
    logic [7:0] m [3] = '{8'hFF, 8'h80, 8'h10};
    uid_sense_t e [4] = '{UID_FACTORY, UID_FLOATING, UID_GROUNDED, UID_GROUNDED};
    #1;
    chk(full_restart_enable_bit, 0);
    chk(usb_reg_input_switch, 0);
    for (int i = 0; i < 4; i++) begin
      tick(1);
      {usb_id_gnd_cmp, usb_id_float_cmp} <= 2'(i);
      irq_pending <= p[i%3];
      irq_mask <= m[i%3];
      tick(3);
      #1;
      chk(usb_id_sense, e[i]);
      chk(int_out, 8'(|(p[i%3] & ~m[i%3])));
    end
    wr(1, 1);
    chk(usb_bus_to_supply_on, 1);
    wr(1, 0);
    chk(usb_bus_to_supply_on, 0);
    chk(power_state, PM_OFF);
    chk(periph_reset_n, 0);
    chk(periph_slow_clock_out, 0);
    chk(host_slow_clock_out, 0);
  endtask : t_basics
  task automatic t_standby;
    sleep(1, 1, 20);
    chk(standby_event, 0);
    sleep(1, 0, 1);
    sleep(1, 1, 20);
    chk(standby_event, 0);
    sleep(1, 0, 20);
    chk(standby_event, 1);
    chk(power_state, PM_STANDBY);
    chk(periph_slow_clock_out, 0);
    sleep(0, 1, 20);
    chk(power_state, PM_ON);
  endtask : t_standby
  task automatic t_restart;
    wr(0, 1);
    key3(80);
    chk(power_state, PM_ON);
    wr(0, 0);
    wr(1, 1);
    key3(20);
    chk(power_state, PM_ON);
    key3(80);
    chk(power_state, PM_RST_POWER_DOWN);
    wait_st(PM_COLD_START, 40);
    chk(power_state, PM_COLD_START);
    chk(usb_reg_input_switch, 0);
    wait_st(PM_ON, 300);
    chk(power_state, PM_ON);
  endtask : t_restart
  task automatic t_wdog;
    tick(1);
    watchdog_keepalive_in <= 0;
    host_clk_lpoff_stop <= 1;
    wait_st(PM_OFF, 20);
    chk(power_state, PM_OFF);
    tick(1);
    #1;
    chk(host_slow_clock_out, 0);
    tick(1);
    watchdog_keepalive_in <= 1;
    t_on(1, 1, 2'h2, OPMODE_USB_LP_BOOT);
    tick(1);
    core_sda_pull_low <= 1;
    serial_clk_pin <= 1;
    tick(6);
    #1;
    chk(data_out_pin_oe_n, 0);
    chk(core_sda_in, 0);
    chk(core_serial_clk, 1);
    tick(1);
    core_sda_pull_low <= 0;
    tick(6);
    #1;
    chk(core_sda_in, 1);
    tick(1);
    wdog_fail_to_cold_start <= 1;
    watchdog_keepalive_in <= 0;
    straps(0, 2'h1, OPMODE_TEST);
    wait_st(PM_COLD_START, 20);
    chk(power_state, PM_COLD_START);
    tick(1);
    watchdog_keepalive_in <= 1;
    wait_st(PM_ON, 300);
    chk_straps(0, 2'h1, OPMODE_TEST);
    tick(1);
    core_miso <= 1;
    core_miso_en <= 1;
    tick(2);
    #1;
    chk(data_out_pin_out, 1);
    chk(data_out_pin_oe_n, 0);
  endtask : t_wdog
  // Main sequence
  initial begin
    tick(4);
    rst <= 0;
    tick(3);
    t_basics();
    sleep(0, 1, 2);
    t_on(0, 0, 2'h3, OPMODE_NORMAL);
    t_standby();
    t_restart();
    t_wdog();
    stop_test();
  end
  // Hang guard, far beyond the some 1200 cycles the run needs
  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : power_control_pin_logic_test
`default_nettype wire
